// ---- bench/atduc_host.sv ----
`timescale 1ns/100ps
module atduc_host (
    input wire logic ref_clk_i, // system clock
    output logic [3:0] io_addr_o, // i/o offset
    output logic [7:0] io_data_o, // write data
    output logic io_wr_n_o // write strobe, active low
);
    initial
    begin
        io_addr_o = 4'h0;
        io_data_o = 8'h00;
        io_wr_n_o = 1'b1;
    end
    // one write; lines held past the strobe's end, then scrambled
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge ref_clk_i);
        #1;
        io_addr_o = a;
        io_data_o = d;
        io_wr_n_o = 1'b0;
        repeat (4) @(posedge ref_clk_i);
        #1;
        io_wr_n_o = 1'b1;
        repeat (4) @(posedge ref_clk_i);
        #1;
        io_addr_o = ~a;
        io_data_o = ~d;
    endtask
endmodule

// ---- bench/tb_acq_trigger_dac_update_ctrl.sv ----
`timescale 1ns/100ps
module tb_acq_trigger_dac_update_ctrl;
    logic ref_clk_i = 1'b0;
    logic nrst_i = 1'b0;
    logic trig = 1'b0;
    logic upd = 1'b1;
    logic avail = 1'b0;
    logic [3:0] addr;
    logic [7:0] data;
    logic wr_n;
    logic [11:0] dac_channel_0, dac_channel_1, v;
    logic conv, act, irq, dma;
    atduc_pkg::atduc_irq_dma_type en;
    int err_count = 0;
    int n_checks = 0;
    int n, t0;
    always #5 ref_clk_i = ~ref_clk_i;
    atduc_host host (.ref_clk_i(ref_clk_i), .io_addr_o(addr), .io_data_o(data), .io_wr_n_o(wr_n));
    atduc_ctrl dut (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .io_addr_i(addr), .io_data_i(data),
        .io_wr_n_i(wr_n), .ext_trigger_pin_i(trig), .ext_dac_update_pin_i(upd),
        .fifo_data_avail_i(avail), .dac_channel_0_code_o(dac_channel_0), .dac_channel_1_code_o(dac_channel_1), .convert_o(conv),
        .acq_active_o(act), .cnt_irq_o(irq), .dma_req_o(dma), .irq_dma_ctrl_o(en));
    task automatic chk(input string s, input logic [11:0] e, input logic [11:0] g);
        n_checks++;
        if (g !== e)
        begin
            err_count++;
            $display("Error %s expected %h seen %h", s, e, g);
        end
    endtask
    task automatic cyc(input int k);
        repeat (k) @(posedge ref_clk_i);
        #1;
    endtask
    task automatic dacw(input int c, input logic [11:0] d);
        host.wr(4'(4 + 2 * c), d[7:0]);
        host.wr(4'(5 + 2 * c), {4'h0, d[11:8]});
    endtask
    task automatic cntw(input int k, input logic [15:0] d);
        host.wr(4'(8 + 2 * k), d[7:0]);
        host.wr(4'(9 + 2 * k), d[15:8]);
    endtask
    function automatic logic [11:0] code(input logic tc, input logic [11:0] d);
        return tc ? {~d[11], d[10:0]} : d;
    endfunction
    task automatic wait_act(input logic lvl, input int lim);
        for (n = 0; n < lim && act !== lvl; n++) cyc(1);
        chk("acq_active", {11'h0, lvl}, {11'h0, act});
    endtask
    task automatic wait_conv;
        for (n = 0; n < 2000 && conv !== 1'b1; n++) cyc(1);
    endtask
    // start, measure strobe spacing in cycles, stop by clearing the start bit
    task automatic acq(input logic [7:0] m, input int sp);
        host.wr(4'h1, m);
        wait_act(1'b1, 50);
        wait_conv();
        t0 = int'($time);
        cyc(1);
        wait_conv();
        chk("spacing", 12'(sp), 12'((int'($time) - t0) / 10));
        host.wr(4'h1, 8'h00);
        wait_act(1'b0, 10);
    endtask
    task automatic final_report;
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    initial
    begin
        #500_000;
        err_count++;
        final_report();
    end
    initial
    begin
        void'($urandom(85));
        cyc(8);
        nrst_i = 1'b1;
        cyc(1);
        chk("dac_channel_0", 12'h000, dac_channel_0);
        chk("enables", 12'h000, {4'h0, en});
        cntw(2, 16'hFFFF);
        v = 12'($urandom);
        host.wr(4'h2, v[7:0]);
        host.wr(4'h0, 8'hFF);
        host.wr(4'h3, 8'hFF);
        avail = 1'b1;
        cyc(3);
        chk("enables", {6'h00, v[5:0]}, {4'h0, en});
        chk("dma_req", {11'h0, v[0]}, {11'h0, dma});
        host.wr(4'h2, {v[7:1], ~v[0]});
        cyc(3);
        chk("dma_req", {11'h0, ~v[0]}, {11'h0, dma});
        avail = 1'b0;
        cyc(3);
        chk("dma_req", 12'h000, {11'h0, dma});
        $display("test enables done");
        for (int i = 0; i < 4; i++)
        begin
            host.wr(4'h1, {2'b00, 2'(i), 4'h0});
            v = (i == 0) ? 12'h800 : 12'($urandom);
            dacw(0, v);
            dacw(1, ~v);
            cyc(8);
            chk("dac_channel_0", code(i[0], v), dac_channel_0);
            chk("dac_channel_1", code(i[1], ~v), dac_channel_1);
        end
        $display("test immediate dac done");
        host.wr(4'h2, 8'h08);
        host.wr(4'h1, 8'hC0);
        dacw(0, 12'h5A5);
        dacw(1, 12'hA5A);
        cyc(8);
        chk("dac_channel_0 held", 12'h001, {11'h0, dac_channel_0 !== 12'h5A5});
        chk("dac_channel_1 held", 12'h001, {11'h0, dac_channel_1 !== 12'hA5A});
        upd = 1'b0;
        cyc(4);
        upd = 1'b1;
        for (n = 0; n < 12 && irq !== 1'b1; n++) cyc(1);
        chk("cnt_irq", 12'h001, {11'h0, irq});
        cyc(4);
        chk("dac_channel_0", 12'h5A5, dac_channel_0);
        chk("dac_channel_1", 12'hA5A, dac_channel_1);
        $display("test timed dac done");
        cntw(0, 16'h0003);
        cntw(3, 16'h0004);
        cntw(1, 16'h0100);
        acq(8'h04, 300);
        acq(8'h0C, 600);
        cntw(1, 16'h0002);
        host.wr(4'h1, 8'h04);
        wait_act(1'b1, 50);
        wait_act(1'b0, 3000);
        $display("test soft trigger done");
        host.wr(4'h1, 8'h02);
        cyc(20);
        chk("armed idle", 12'h000, {11'h0, act});
        trig = 1'b1;
        wait_act(1'b1, 10);
        wait_act(1'b0, 3000);
        trig = 1'b0;
        host.wr(4'h1, 8'h05);
        cyc(1500);
        chk("pretrigger", 12'h001, {11'h0, act});
        trig = 1'b1;
        wait_act(1'b0, 3000);
        $display("test hardware and pretrigger done");
        final_report();
    end
endmodule

// ---- src/atduc_counter.sv ----
`timescale 1ns/100ps
module atduc_counter (
    input wire logic ref_clk_i,                          // system clock
    input wire logic nrst_i,                             // async reset, active low
    input wire logic [atduc_pkg::CNT_W-1:0] load_i,      // reload value
    input wire logic run_i,                              // gate: low holds the load value
    input wire logic tick_i,                             // count enable pulse
    output logic tc_o                                    // one-cycle terminal count pulse
);
    logic [atduc_pkg::CNT_W-1:0] count;
    logic [atduc_pkg::CNT_W-1:0] next_count;
    logic next_tc;

    always_comb
    begin
        next_count = count;
        next_tc = 1'b0;
        if (!run_i)
        begin
            next_count = load_i;
        end
        else if (tick_i)
        begin
            if (count <= atduc_pkg::CNT_W'(1))
            begin
                next_tc = 1'b1;
                next_count = load_i;
            end
            else
            begin
                next_count = count - atduc_pkg::CNT_W'(1);
            end
        end
    end

    always_ff @(posedge ref_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            count <= atduc_pkg::CNT_LOAD_RST;
            tc_o <= 1'b0;
        end
        else
        begin
            count <= next_count;
            tc_o <= next_tc;
        end
    end

    a_cnt_idle_quiet: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
        !run_i |=> !tc_o)
        else $error("terminal count while gate low");
endmodule

// ---- src/atduc_ctrl.sv ----
`timescale 1ns/100ps
module atduc_ctrl (
    input wire logic ref_clk_i,                              // system clock, 100 MHz
    input wire logic nrst_i,                                 // async reset, active low
    input wire logic [3:0] io_addr_i,                        // i/o offset from base
    input wire logic [7:0] io_data_i,                        // i/o write data
    input wire logic io_wr_n_i,                              // i/o write strobe, active low
    input wire logic ext_trigger_pin_i,                      // external trigger pin
    input wire logic ext_dac_update_pin_i,                   // external dac update pin
    input wire logic fifo_data_avail_i,                      // conversion result waiting
    output logic [atduc_pkg::DAC_W-1:0] dac_channel_0_code_o,         // dac 0 converter code
    output logic [atduc_pkg::DAC_W-1:0] dac_channel_1_code_o,         // dac 1 converter code
    output logic convert_o,                                  // one-cycle sample strobe
    output logic acq_active_o,                               // acquisition in progress
    output logic cnt_irq_o,                                  // one-cycle counter interrupt
    output logic dma_req_o,                                  // dma request level
    output atduc_pkg::atduc_irq_dma_type irq_dma_ctrl_o      // enable register contents
);
    // input synchronisers
    logic [atduc_pkg::SYNC_W-1:0] sync_1;
    logic [atduc_pkg::SYNC_W-1:0] sync_2;
    logic wr_n_d;
    logic trig_d;
    logic upd_d;
    logic wr_done;
    logic trig_rise;
    logic upd_rise;
    atduc_pkg::atduc_wr_type wr;

    always_ff @(posedge ref_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            sync_1 <= {atduc_pkg::SYNC_W{1'b1}};
            sync_2 <= {atduc_pkg::SYNC_W{1'b1}};
            wr_n_d <= 1'b1;
            trig_d <= 1'b1;
            upd_d <= 1'b1;
        end
        else
        begin
            sync_1 <= {io_wr_n_i, ext_trigger_pin_i, ext_dac_update_pin_i, io_addr_i, io_data_i};
            sync_2 <= sync_1;
            wr_n_d <= sync_2[14];
            trig_d <= sync_2[13];
            upd_d <= sync_2[12];
        end
    end

    // a write takes effect at the end of the strobe
    assign wr_done = sync_2[14] && !wr_n_d;
    assign trig_rise = sync_2[13] && !trig_d;
    assign upd_rise = sync_2[12] && !upd_d;
    assign wr = sync_2[11:0];

    // 1 MHz and 2 MHz enable dividers
    logic [atduc_pkg::DIV_W-1:0] div_int;
    logic [atduc_pkg::DIV_W-1:0] div_pre;
    logic [atduc_pkg::DIV_W-1:0] next_div_int;
    logic [atduc_pkg::DIV_W-1:0] next_div_pre;
    logic tick_1m;
    logic tick_2m;

    always_comb
    begin
        tick_1m = (div_int == atduc_pkg::DIV_W'(atduc_pkg::DIV_INT_CLK - 1));
        tick_2m = (div_pre == atduc_pkg::DIV_W'(atduc_pkg::DIV_PRESCALE - 1));
        next_div_int = tick_1m ? '0 : div_int + atduc_pkg::DIV_W'(1);
        next_div_pre = tick_2m ? '0 : div_pre + atduc_pkg::DIV_W'(1);
    end

    always_ff @(posedge ref_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            div_int <= '0;
            div_pre <= '0;
        end
        else
        begin
            div_int <= next_div_int;
            div_pre <= next_div_pre;
        end
    end

    // register file, write-only: there is no read path at all
    atduc_pkg::atduc_mode_type mode;
    atduc_pkg::atduc_mode_type next_mode;
    atduc_pkg::atduc_irq_dma_type irq_dma;
    atduc_pkg::atduc_irq_dma_type next_irq_dma;
    logic [7:0] dac_lo [atduc_pkg::NUM_DAC];
    logic [7:0] next_dac_lo [atduc_pkg::NUM_DAC];
    logic [atduc_pkg::DAC_W-1:0] dac_data [atduc_pkg::NUM_DAC];
    logic [atduc_pkg::DAC_W-1:0] next_dac_data [atduc_pkg::NUM_DAC];
    logic [atduc_pkg::CNT_W-1:0] cnt_load [atduc_pkg::NUM_CNT];
    logic [atduc_pkg::CNT_W-1:0] next_cnt_load [atduc_pkg::NUM_CNT];
    logic [atduc_pkg::NUM_DAC-1:0] dac_load;
    logic [atduc_pkg::NUM_DAC-1:0] next_dac_load;
    logic soft_start;
    logic next_soft_start;

    function automatic logic hit(input logic [3:0] addr, input logic [3:0] ofs);
        hit = (addr == ofs);
    endfunction

    always_comb
    begin
        next_mode = mode;
        next_irq_dma = irq_dma;
        next_dac_lo = dac_lo;
        next_dac_data = dac_data;
        next_cnt_load = cnt_load;
        next_dac_load = '0;
        next_soft_start = 1'b0;
        if (wr_done)
        begin
            if (hit(wr.addr, atduc_pkg::OFS_MODE_CTRL))
            begin
                next_mode = wr.data;
                next_soft_start = wr.data[2];
            end
            if (hit(wr.addr, atduc_pkg::OFS_IRQ_DMA_CTRL))
            begin
                next_irq_dma = {2'b00, wr.data[5:0]};
            end
            for (int i = 0; i < atduc_pkg::NUM_DAC; i++)
            begin
                if (hit(wr.addr, atduc_pkg::OFS_DAC_BASE + 4'(2 * i)))
                begin
                    next_dac_lo[i] = wr.data;
                end
                if (hit(wr.addr, atduc_pkg::OFS_DAC_BASE + 4'(2 * i + 1)))
                begin
                    next_dac_data[i] = {wr.data[3:0], dac_lo[i]};
                    next_dac_load[i] = 1'b1;
                end
            end
            for (int k = 0; k < atduc_pkg::NUM_CNT; k++)
            begin
                if (hit(wr.addr, atduc_pkg::OFS_CNT_BASE + 4'(2 * k)))
                begin
                    next_cnt_load[k][7:0] = wr.data;
                end
                if (hit(wr.addr, atduc_pkg::OFS_CNT_BASE + 4'(2 * k + 1)))
                begin
                    next_cnt_load[k][15:8] = wr.data;
                end
            end
        end
    end

    always_ff @(posedge ref_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            mode <= atduc_pkg::MODE_CTRL_RST;
            irq_dma <= atduc_pkg::IRQ_DMA_RST;
            dac_lo <= '{default: atduc_pkg::BYTE_RST};
            dac_data <= '{default: atduc_pkg::DAC_RST};
            cnt_load <= '{default: atduc_pkg::CNT_LOAD_RST};
            dac_load <= '0;
            soft_start <= 1'b0;
        end
        else
        begin
            mode <= next_mode;
            irq_dma <= next_irq_dma;
            dac_lo <= next_dac_lo;
            dac_data <= next_dac_data;
            cnt_load <= next_cnt_load;
            dac_load <= next_dac_load;
            soft_start <= next_soft_start;
        end
    end

    // counters: interval, sample count, dac update, prescale
    logic [atduc_pkg::NUM_CNT-1:0] cnt_run;
    logic [atduc_pkg::NUM_CNT-1:0] cnt_tick;
    logic [atduc_pkg::NUM_CNT-1:0] cnt_tc;
    atduc_pkg::atduc_acq_state_type acq_state;
    atduc_pkg::atduc_acq_state_type next_acq_state;

    always_comb
    begin
        cnt_run[atduc_pkg::CNT_INTERVAL] = (acq_state != atduc_pkg::ACQ_IDLE);
        cnt_tick[atduc_pkg::CNT_INTERVAL] = mode.timebase_select ?
            cnt_tc[atduc_pkg::CNT_PRESCALE] : tick_1m;
        cnt_run[atduc_pkg::CNT_SAMPLES] = (acq_state == atduc_pkg::ACQ_RUN);
        cnt_tick[atduc_pkg::CNT_SAMPLES] = cnt_tc[atduc_pkg::CNT_INTERVAL];
        cnt_run[atduc_pkg::CNT_DAC_UPD] = 1'b1;
        cnt_tick[atduc_pkg::CNT_DAC_UPD] = tick_1m;
        cnt_run[atduc_pkg::CNT_PRESCALE] = 1'b1;
        cnt_tick[atduc_pkg::CNT_PRESCALE] = tick_2m;
    end

    generate
        for (genvar g = 0; g < atduc_pkg::NUM_CNT; g++)
        begin : g_cnt
            atduc_counter u_cnt (
                .ref_clk_i(ref_clk_i),
                .nrst_i(nrst_i),
                .load_i(cnt_load[g]),
                .run_i(cnt_run[g]),
                .tick_i(cnt_tick[g]),
                .tc_o(cnt_tc[g])
            );
        end
    endgenerate

    // acquisition sequencer
    logic programmed;

    always_comb
    begin
        programmed = (cnt_load[atduc_pkg::CNT_INTERVAL] != atduc_pkg::CNT_LOAD_RST);
        next_acq_state = acq_state;
        case (acq_state)
            atduc_pkg::ACQ_IDLE:
            begin
                if (soft_start && programmed)
                begin
                    next_acq_state = mode.pretrigger_mode ?
                        atduc_pkg::ACQ_PRE : atduc_pkg::ACQ_RUN;
                end
                else if (mode.ext_trigger_arm && trig_rise && programmed)
                begin
                    next_acq_state = atduc_pkg::ACQ_RUN;
                end
            end
            atduc_pkg::ACQ_PRE:
            begin
                if (!mode.soft_trigger)
                begin
                    next_acq_state = atduc_pkg::ACQ_IDLE;
                end
                else if (trig_rise)
                begin
                    next_acq_state = atduc_pkg::ACQ_RUN;
                end
            end
            atduc_pkg::ACQ_RUN:
            begin
                if (cnt_tc[atduc_pkg::CNT_SAMPLES])
                begin
                    next_acq_state = atduc_pkg::ACQ_IDLE;
                end
                else if (!mode.soft_trigger && !mode.ext_trigger_arm)
                begin
                    next_acq_state = atduc_pkg::ACQ_IDLE;
                end
            end
            default:
            begin
                next_acq_state = atduc_pkg::ACQ_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            acq_state <= atduc_pkg::ACQ_IDLE;
        end
        else
        begin
            acq_state <= next_acq_state;
        end
    end

    // dac output latches and output registers
    logic upd_evt;
    logic [atduc_pkg::NUM_DAC-1:0] timed;
    logic [atduc_pkg::NUM_DAC-1:0] twos;
    logic [atduc_pkg::DAC_W-1:0] dac_hold [atduc_pkg::NUM_DAC];
    logic [atduc_pkg::DAC_W-1:0] next_dac_hold [atduc_pkg::NUM_DAC];
    logic [atduc_pkg::DAC_W-1:0] next_code [atduc_pkg::NUM_DAC];

    always_comb
    begin
        upd_evt = cnt_tc[atduc_pkg::CNT_DAC_UPD] || upd_rise;
        timed = {mode.timed_update_dac_channel_1, mode.timed_update_dac_channel_0};
        twos = {mode.twos_comp_dac_channel_1, mode.twos_comp_dac_channel_0};
        for (int i = 0; i < atduc_pkg::NUM_DAC; i++)
        begin
            next_dac_hold[i] = dac_hold[i];
            if (timed[i] && upd_evt)
            begin
                next_dac_hold[i] = dac_data[i];
            end
            else if (!timed[i] && dac_load[i])
            begin
                next_dac_hold[i] = dac_data[i];
            end
            // two's complement becomes offset binary by flipping the sign bit
            next_code[i] = {dac_hold[i][11] ^ twos[i], dac_hold[i][10:0]};
        end
    end

    always_ff @(posedge ref_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            dac_hold <= '{default: atduc_pkg::DAC_RST};
            dac_channel_0_code_o <= atduc_pkg::DAC_RST;
            dac_channel_1_code_o <= atduc_pkg::DAC_RST;
            convert_o <= 1'b0;
            acq_active_o <= 1'b0;
            cnt_irq_o <= 1'b0;
            dma_req_o <= 1'b0;
            irq_dma_ctrl_o <= atduc_pkg::IRQ_DMA_RST;
        end
        else
        begin
            dac_hold <= next_dac_hold;
            dac_channel_0_code_o <= next_code[0];
            dac_channel_1_code_o <= next_code[1];
            convert_o <= cnt_tc[atduc_pkg::CNT_INTERVAL];
            acq_active_o <= (acq_state != atduc_pkg::ACQ_IDLE);
            cnt_irq_o <= irq_dma.counter_irq_en && upd_evt;
            dma_req_o <= irq_dma.dma_request_en && fifo_data_avail_i;
            irq_dma_ctrl_o <= irq_dma;
        end
    end

    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (!nrst_i);

    a_tick_1m_period: assert property (tick_1m |-> ##100 tick_1m)
        else $error("1 MHz enable not every 100 cycles");
    a_tick_2m_period: assert property (tick_2m |-> ##50 tick_2m)
        else $error("2 MHz enable not every 50 cycles");
    a_timed_dac_hold: assert property (timed[0] && !upd_evt |=> $stable(dac_hold[0]))
        else $error("timed dac 0 changed without update event");
    a_immed_dac_load: assert property (!timed[1] && dac_load[1] |=> ##1
        dac_channel_1_code_o == {$past(dac_data[1][11], 2) ^ $past(twos[1]), $past(dac_data[1][10:0], 2)})
        else $error("immediate dac 1 did not follow its data");
    a_soft_start_run: assert property (acq_state == atduc_pkg::ACQ_IDLE && soft_start
        && programmed && !mode.pretrigger_mode |=> acq_state == atduc_pkg::ACQ_RUN ##1
        acq_active_o)
        else $error("soft trigger did not start acquisition");
    a_soft_clear_stop: assert property (acq_state == atduc_pkg::ACQ_RUN
        && !mode.soft_trigger && !mode.ext_trigger_arm |=> acq_state == atduc_pkg::ACQ_IDLE)
        else $error("cleared soft trigger left counter running");
    a_count_ends_acq: assert property (acq_state == atduc_pkg::ACQ_RUN
        && cnt_tc[atduc_pkg::CNT_SAMPLES] |=> acq_state == atduc_pkg::ACQ_IDLE)
        else $error("sample count terminal count did not end acquisition");
    a_pre_no_count: assert property (acq_state == atduc_pkg::ACQ_PRE
        |-> !cnt_run[atduc_pkg::CNT_SAMPLES])
        else $error("sample count ran before trigger edge");
    a_arm_start_run: assert property (acq_state == atduc_pkg::ACQ_IDLE && !soft_start
        && mode.ext_trigger_arm && trig_rise && programmed
        |=> acq_state == atduc_pkg::ACQ_RUN)
        else $error("trigger edge did not start armed acquisition");
    a_cnt_irq_gate: assert property (cnt_irq_o == $past(irq_dma.counter_irq_en && upd_evt))
        else $error("counter interrupt not tied to enable and event");
    a_dma_req_gate: assert property (!irq_dma.dma_request_en |=> !dma_req_o)
        else $error("dma request with enable clear");

    c_soft_run: cover property (acq_state == atduc_pkg::ACQ_IDLE ##1
        acq_state == atduc_pkg::ACQ_RUN);
    c_pre_to_run: cover property (acq_state == atduc_pkg::ACQ_PRE ##1
        acq_state == atduc_pkg::ACQ_RUN);
    c_timed_update: cover property (timed[0] && upd_evt);
    c_prescaled: cover property (mode.timebase_select && convert_o);
endmodule

// ---- src/atduc_pkg.sv ----
package atduc_pkg;
    // timing: system clock, internal sample clock, prescale timebase
    localparam int CLK_HZ = 100_000_000;
    localparam int INT_CLK_HZ = 1_000_000;
    localparam int PRESCALE_BASE_HZ = 2_000_000;
    localparam int DIV_INT_CLK = CLK_HZ / INT_CLK_HZ;
    localparam int DIV_PRESCALE = CLK_HZ / PRESCALE_BASE_HZ;
    localparam int DIV_W = 7;

    // i/o offsets from the board base address
    localparam logic [3:0] OFS_MODE_CTRL = 4'h1;
    localparam logic [3:0] OFS_IRQ_DMA_CTRL = 4'h2;
    localparam logic [3:0] OFS_DAC_BASE = 4'h4;
    localparam logic [3:0] OFS_CNT_BASE = 4'h8;

    // values after reset
    localparam logic [7:0] MODE_CTRL_RST = 8'h00;
    localparam logic [7:0] IRQ_DMA_RST = 8'h00;
    localparam logic [7:0] BYTE_RST = 8'h00;
    localparam logic [11:0] DAC_RST = 12'h000;
    localparam logic [15:0] CNT_LOAD_RST = 16'h0000;

    // widths and counts
    localparam int DAC_W = 12;
    localparam int CNT_W = 16;
    localparam int NUM_DAC = 2;
    localparam int NUM_CNT = 4;
    localparam int SYNC_W = 15;

    // counter slots
    localparam int CNT_INTERVAL = 0;
    localparam int CNT_SAMPLES = 1;
    localparam int CNT_DAC_UPD = 2;
    localparam int CNT_PRESCALE = 3;

    // trigger and dac mode control, bit 7 down to bit 0
    typedef struct packed {
        logic timed_update_dac_channel_1;
        logic timed_update_dac_channel_0;
        logic twos_comp_dac_channel_1;
        logic twos_comp_dac_channel_0;
        logic timebase_select;
        logic soft_trigger;
        logic ext_trigger_arm;
        logic pretrigger_mode;
    } atduc_mode_type;

    // interrupt and dma enables, bits 7 and 6 ignored
    typedef struct packed {
        logic [1:0] ignored;
        logic fifo_irq_en;
        logic error_irq_en;
        logic counter_irq_en;
        logic term_count_irq_en;
        logic dio_irq_en;
        logic dma_request_en;
    } atduc_irq_dma_type;

    // one completed host write
    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] data;
    } atduc_wr_type;

    typedef enum logic [1:0] {
        ACQ_IDLE,
        ACQ_PRE,
        ACQ_RUN
    } atduc_acq_state_type;
endpackage
